// file: logic/bcast_filter_pkg.sv
// Purpose: Shared constants and carriers of the broadcast frame filter
// Assumes: One 50 MHz clock; APB register access with 32-bit data
// Notes:   Frame offsets count bytes from the first destination MAC byte
package bcast_filter_pkg;
    // APB register byte addresses
    localparam logic [11:0] OFS_SETTINGS = 12'h000;
    localparam logic [11:0] OFS_COMMAND  = 12'h004;
    localparam logic [11:0] OFS_ACTIVE   = 12'h008;
    localparam logic [11:0] OFS_STATUS   = 12'h00c;
    localparam logic [11:0] OFS_CAPS     = 12'h010;
    // Field positions
    localparam int STAT_EN_BIT   = 0;
    localparam int STAT_RESP_LSB = 8;
    localparam int CMD_CODE_W    = 8;
    // Command packet byte layout: header, settings word, checksum, pad
    localparam int PKT_SETTINGS_OFS = 16;
    localparam int PKT_CHECKSUM_OFS = 20;
    localparam int PKT_PAD_OFS      = 24;
    // Command and response packet types
    localparam logic [7:0] CMD_ENABLE   = 8'h10;
    localparam logic [7:0] CMD_DISABLE  = 8'h11;
    localparam logic [7:0] RESP_ENABLE  = 8'h90;
    localparam logic [7:0] RESP_DISABLE = 8'h91;
    localparam logic [7:0] RESP_NONE    = 8'h00;
    // Class bit positions in the settings word
    localparam int CLS_ARP   = 0;
    localparam int CLS_DHCPC = 1;
    localparam int CLS_DHCPS = 2;
    localparam int CLS_NBIOS = 3;
    localparam int NUM_CLS   = 4;
    // Classes this channel implements, reported in the capability register
    localparam logic [3:0] CAP_CLASSES = 4'hf;
    // Frame parsing
    localparam logic [7:0]  BCAST_OCTET  = 8'hff;
    localparam logic [10:0] MAC_LAST_POS = 11'h005;
    localparam logic [10:0] ETYPE_HI_POS = 11'h00c;
    localparam logic [10:0] ETYPE_LO_POS = 11'h00d;
    localparam logic [10:0] IP_START_POS = 11'h00e;
    localparam logic [10:0] PROTO_POS    = 11'h017;
    localparam logic [10:0] UDP_DPORT_OFS = 11'h002;
    localparam logic [10:0] POS_MAX      = 11'h7ff;
    localparam logic [15:0] ETYPE_ARP    = 16'h0806;
    localparam logic [15:0] ETYPE_IPV4   = 16'h0800;
    localparam logic [7:0]  PROTO_UDP    = 8'h11;
    localparam logic [15:0] PORT_DHCPC   = 16'h0044;
    localparam logic [15:0] PORT_DHCPS   = 16'h0043;
    localparam logic [15:0] PORT_NB_NAME = 16'h0089;
    localparam logic [15:0] PORT_NB_DGRM = 16'h008a;
    localparam int FIFO_DEPTH = 16;
    // Received byte of a frame
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } rx_byte_t;
    // Per-frame decision
    typedef struct packed {
        logic       bcast;
        logic       forward;
        logic [3:0] cls;
    } verdict_t;
endpackage

// file: logic/broadcast_frame_filter.sv
// Purpose: Decide per received frame whether broadcast traffic reaches the manager
// Assumes: Byte stream with valid/ready on core_clk; APB slave with zero wait
// Notes:   Verdicts queue in a FIFO; a full FIFO stalls the byte stream
//
// The address map and the APB slave port are this design's own decisions.

// Verdict queue kept in flip-flops
module verdict_fifo #(
    parameter int W     = 6,
    parameter int DEPTH = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);
    localparam logic [PW-1:0] PTR_ONE  = PW'(1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wr;
        logic [PW-1:0]           rd;
        logic [CW-1:0]           cnt;
        logic                    ready;
        logic                    valid;
    } fifo_st_t;

    fifo_st_t s_q;
    fifo_st_t s_d;
    logic     push;
    logic     pop;

    assign inReady  = s_q.ready;
    assign outValid = s_q.valid;
    assign outData  = s_q.mem[s_q.rd];

    // Ready and valid are flops of their own, so neither depends on the far side
    always_comb begin
        s_d  = s_q;
        push = inValid && s_q.ready;
        pop  = outReady && s_q.valid;
        if (push) begin
            s_d.mem[s_q.wr] = inData;
            s_d.wr = s_q.wr + PTR_ONE;
        end
        if (pop) begin
            s_d.rd = s_q.rd + PTR_ONE;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + CNT_ONE;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - CNT_ONE;
        end
        s_d.ready = (s_d.cnt != CNT_FULL);
        s_d.valid = (s_d.cnt != '0);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q       <= '0;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // verdict_fifo

// Notes on behaviour
// - after enable command, broadcast frames pass or drop per its class selections
// - no class selected means every broadcast frame is dropped
// - command layout is header, settings word, checksum, then pad bytes
// - a class bit of one forwards matching frames, zero drops them
// - bit 0 is ARP: broadcast destination, Ethertype 0x0806; always supported
// - bit 1 is DHCP client: broadcast, IPv4, UDP, destination port 68
// - bit 2 is DHCP server: broadcast, IPv4, UDP, destination port 67
// - bit 3 is NetBIOS: broadcast, IPv4, UDP, destination port 137 or 138
// - unimplemented optional classes are dropped while filtering is active
// - settings bits of unimplemented classes count as zero
// - a capability field reports which classes are implemented
// - command code 0x10 loads the settings word and enables filtering
// - accepted enable command answers with response type 0x90
// - command code 0x11 stops filtering; all broadcast frames then pass
module broadcast_frame_filter (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        rxValid,
    input  wire bcast_filter_pkg::rx_byte_t  rxByte,
    output logic                             rxReady,
    output logic                             verdictValid,
    output bcast_filter_pkg::verdict_t       verdict,
    input  wire logic                        verdictReady
);
    typedef struct packed {
        logic [31:0] stage;
        logic [31:0] active;
        logic        filtEn;
        logic [7:0]  resp;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [10:0] pos;
        logic        bc;
        logic [15:0] etype;
        logic [3:0]  ihl;
        logic [7:0]  proto;
        logic [15:0] port;
    } filt_st_t;

    filt_st_t                   s_q;
    filt_st_t                   s_d;
    bcast_filter_pkg::verdict_t vd;
    logic                       take;
    logic                       push;
    logic                       ipUdp;
    logic [3:0]                 cls;
    logic [3:0]                 allowed;
    logic [10:0]                portPos;
    logic [31:0]                rdVal;
    logic                       mapped;
    logic [7:0]                 cmdCode;

    assign prdata  = s_q.prdata;
    assign pready  = s_q.pready;
    assign pslverr = s_q.pslverr;

    // Class match from the header fields gathered so far
    always_comb begin
        ipUdp = s_q.bc && (s_q.etype == bcast_filter_pkg::ETYPE_IPV4)
                && (s_q.proto == bcast_filter_pkg::PROTO_UDP);
        cls = '0;
        cls[bcast_filter_pkg::CLS_ARP] = s_q.bc
            && (s_q.etype == bcast_filter_pkg::ETYPE_ARP);
        cls[bcast_filter_pkg::CLS_DHCPC] = ipUdp
            && (s_q.port == bcast_filter_pkg::PORT_DHCPC);
        cls[bcast_filter_pkg::CLS_DHCPS] = ipUdp
            && (s_q.port == bcast_filter_pkg::PORT_DHCPS);
        cls[bcast_filter_pkg::CLS_NBIOS] = ipUdp
            && ((s_q.port == bcast_filter_pkg::PORT_NB_NAME)
            || (s_q.port == bcast_filter_pkg::PORT_NB_DGRM));
        // Only implemented class bits count; reserved bits are cut off
        allowed = s_q.active[bcast_filter_pkg::NUM_CLS-1:0]
                  & bcast_filter_pkg::CAP_CLASSES;
        vd.bcast = s_q.bc;
        vd.cls   = cls;
        // Non-broadcast and unfiltered traffic always passes on
        vd.forward = !s_q.bc || !s_q.filtEn
                     || ((cls & allowed) != '0);
    end

    // Register read mux and address decode
    always_comb begin
        rdVal  = '0;
        mapped = 1'b1;
        unique case (paddr)
            bcast_filter_pkg::OFS_SETTINGS: rdVal = s_q.stage;
            bcast_filter_pkg::OFS_COMMAND:  rdVal = '0;
            bcast_filter_pkg::OFS_ACTIVE:   rdVal = s_q.active;
            bcast_filter_pkg::OFS_STATUS: begin
                rdVal[bcast_filter_pkg::STAT_EN_BIT] = s_q.filtEn;
                rdVal[bcast_filter_pkg::STAT_RESP_LSB +: 8] = s_q.resp;
            end
            bcast_filter_pkg::OFS_CAPS:
                rdVal[bcast_filter_pkg::NUM_CLS-1:0] = bcast_filter_pkg::CAP_CLASSES;
            default: mapped = 1'b0;
        endcase
    end

    assign cmdCode = pwdata[bcast_filter_pkg::CMD_CODE_W-1:0];
    assign portPos = bcast_filter_pkg::IP_START_POS + {5'h00, s_q.ihl, 2'h0}
                     + bcast_filter_pkg::UDP_DPORT_OFS;
    assign take    = rxValid && rxReady;
    assign push    = take && rxByte.last;

    // Next state: APB slave and header parser
    always_comb begin
        s_d = s_q;
        // Zero-wait answer: data and ready prepared in the setup cycle
        s_d.pready  = psel && !penable;
        s_d.pslverr = psel && !penable && !mapped;
        if (psel && !penable) begin
            s_d.prdata = rdVal;
        end
        if (psel && penable && s_q.pready && pwrite && mapped) begin
            // Settings word mirrors the payload word at PKT_SETTINGS_OFS
            if (paddr == bcast_filter_pkg::OFS_SETTINGS) begin
                s_d.stage = pwdata;
            end
            if (paddr == bcast_filter_pkg::OFS_COMMAND) begin
                if (cmdCode == bcast_filter_pkg::CMD_ENABLE) begin
                    s_d.active = s_q.stage;
                    s_d.filtEn = 1'b1;
                    s_d.resp   = bcast_filter_pkg::RESP_ENABLE;
                end else if (cmdCode == bcast_filter_pkg::CMD_DISABLE) begin
                    s_d.filtEn = 1'b0;
                    s_d.resp   = bcast_filter_pkg::RESP_DISABLE;
                end
            end
        end
        // Header capture; the position counter saturates on jumbo frames
        if (take) begin
            if (s_q.pos <= bcast_filter_pkg::MAC_LAST_POS) begin
                s_d.bc = ((s_q.pos == '0) || s_q.bc)
                         && (rxByte.data == bcast_filter_pkg::BCAST_OCTET);
            end
            if (s_q.pos == bcast_filter_pkg::ETYPE_HI_POS) begin
                s_d.etype[15:8] = rxByte.data;
            end
            if (s_q.pos == bcast_filter_pkg::ETYPE_LO_POS) begin
                s_d.etype[7:0] = rxByte.data;
            end
            if (s_q.pos == bcast_filter_pkg::IP_START_POS) begin
                s_d.ihl = rxByte.data[3:0];
            end
            if (s_q.pos == bcast_filter_pkg::PROTO_POS) begin
                s_d.proto = rxByte.data;
            end
            // Port position follows the IP header length, so options are skipped
            if (s_q.pos > bcast_filter_pkg::PROTO_POS && s_q.pos == portPos) begin
                s_d.port[15:8] = rxByte.data;
            end
            if (s_q.pos > bcast_filter_pkg::PROTO_POS
                && s_q.pos == portPos + 11'h001) begin
                s_d.port[7:0] = rxByte.data;
            end
            if (s_q.pos != bcast_filter_pkg::POS_MAX) begin
                s_d.pos = s_q.pos + 11'h001;
            end
            // Fields clear at frame end so a runt never inherits old values
            if (rxByte.last) begin
                s_d.pos   = '0;
                s_d.bc    = 1'b0;
                s_d.etype = '0;
                s_d.ihl   = '0;
                s_d.proto = '0;
                s_d.port  = '0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q      <= '0;
            s_q.resp <= bcast_filter_pkg::RESP_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // Verdict queue; its full flag is the stall on the byte stream
    verdict_fifo #(
        .W     ($bits(bcast_filter_pkg::verdict_t)),
        .DEPTH (bcast_filter_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .inValid  (push),
        .inReady  (rxReady),
        .inData   (vd),
        .outValid (verdictValid),
        .outReady (verdictReady),
        .outData  (verdict)
    );
endmodule // broadcast_frame_filter

// file: tb/broadcast_frame_filter_properties.sv
// Purpose: Port properties of the broadcast frame filter
// Assumes: Commands are issued only while no verdict is queued
// Notes:   Shadows the command state to judge each verdict
module broadcast_frame_filter_checker (
    input wire logic                       core_clk,
    input wire logic                       rst,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [11:0]                paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       rxValid,
    input wire bcast_filter_pkg::rx_byte_t rxByte,
    input wire logic                       rxReady,
    input wire logic                       verdictValid,
    input wire bcast_filter_pkg::verdict_t verdict,
    input wire logic                       verdictReady
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] stage_q;
    logic [31:0] active_q;
    logic [7:0]  resp_q;
    logic        en_q;
    logic        rd;
    logic        wr;
    // Completed reads and writes
    assign rd = psel && penable && pready && !pwrite;
    assign wr = psel && penable && pready && pwrite;
    // Command state as software sees it; a verdict is judged against it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage_q  <= '0;
            active_q <= '0;
            resp_q   <= '0;
            en_q     <= 1'b0;
        end else if (wr && paddr == 12'h000) begin
            stage_q <= pwdata;
        end else if (wr && paddr == 12'h004 && pwdata[7:0] == 8'h10) begin
            active_q <= stage_q;
            en_q     <= 1'b1;
            resp_q   <= 8'h90;
        end else if (wr && paddr == 12'h004 && pwdata[7:0] == 8'h11) begin
            en_q   <= 1'b0;
            resp_q <= 8'h91;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // A setup is answered in the next cycle, for one cycle only
    sequence s_setup; psel && !penable; endsequence
    sequence s_answer; pready ##1 !pready; endsequence
    property p_zero_wait; s_setup |=> s_answer; endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("Setup not answered at once");
    property p_unmapped; psel && penable && pready && paddr > 12'h010 |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused");
    property p_caps; rd && paddr == 12'h010 |-> prdata == 32'h0000000f; endproperty
    a_caps: assert property (p_caps) else $error("Capability field wrong");
    property p_status; rd && paddr == 12'h00c |-> prdata[15:0] == {resp_q, 7'h00, en_q}; endproperty
    a_status: assert property (p_status) else $error("Status word wrong");
    property p_active; rd && paddr == 12'h008 |-> prdata == active_q; endproperty
    a_active: assert property (p_active) else $error("Active settings wrong");
    property p_decide; verdictValid && verdict.bcast
        |-> verdict.forward == (!en_q || (verdict.cls & active_q[3:0]) != 4'h0); endproperty
    a_decide: assert property (p_decide) else $error("Broadcast verdict wrong");
    property p_none_drop; verdictValid && verdict.bcast && en_q && active_q[3:0] == 4'h0
        |-> !verdict.forward; endproperty
    a_none_drop: assert property (p_none_drop) else $error("Broadcast passed");
    property p_other_pass; verdictValid && !verdict.bcast |-> verdict.forward; endproperty
    a_other_pass: assert property (p_other_pass) else $error("Unicast dropped");
endmodule // broadcast_frame_filter_checker

bind broadcast_frame_filter broadcast_frame_filter_checker u_broadcast_frame_filter_checker (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxValid(rxValid), .rxByte(rxByte), .rxReady(rxReady), .verdictValid(verdictValid),
    .verdict(verdict), .verdictReady(verdictReady));

// file: tb/frame_source.sv
// Purpose: Far-end source of received frame bytes
// Assumes: send is called just after a rising clock edge
// Notes:   Idle data is inverted so a stale byte never looks current
module frame_source (
    input  wire logic                  core_clk,
    input  wire logic                  rxReady,
    output logic                       rxValid,
    output bcast_filter_pkg::rx_byte_t rxByte,
    output logic                       hung
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rxValid = 1'b0;
        rxByte  = '0;
        hung    = 1'b0;
    end
    // Each byte stands until rxReady is seen high; UDP over IPv4 with a 20-byte header
    task automatic send(input logic bc, input logic [15:0] et, input logic [15:0] pt,
                        input int len);
        int         n;
        logic [7:0] d;
        for (int i = 0; i < len; i++) begin
            d = i < 6 ? (bc ? 8'hff : 8'h02) : i == 12 ? et[15:8] : i == 13 ? et[7:0] :
                i == 14 ? 8'h45 : i == 23 ? 8'h11 : i == 36 ? pt[15:8] : i == 37 ? pt[7:0] : 8'h00;
            rxValid <= 1'b1;
            rxByte  <= '{data: d, last: i == len - 1};
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (rxReady !== 1'b1 && n < 100);
            if (n >= 100) hung = 1'b1;
        end
        rxValid     <= 1'b0;
        rxByte.data <= ~d;
        @(posedge core_clk);
    endtask
endmodule // frame_source

// file: tb/tb_broadcast_frame_filter.sv
// Purpose: Self-checking bench of the broadcast frame filter
// Assumes: Every bus or frame call starts just after a rising edge
// Notes:   Each verdict is popped before the next command is issued
module tb_broadcast_frame_filter;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        rxValid, rxReady, verdictValid, verdictReady, hung;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          error_cnt, comparisons;
    logic [15:0] ets [6] = '{16'h0806, 16'h0800, 16'h0800, 16'h0800, 16'h0800, 16'h0800};
    logic [15:0] pts [6] = '{16'h0000, 16'h0044, 16'h0043, 16'h0089, 16'h008a, 16'h0035};
    int          cls [6] = '{0, 1, 2, 3, 3, 9};
    bcast_filter_pkg::rx_byte_t rxByte;
    bcast_filter_pkg::verdict_t verdict;
    broadcast_frame_filter u_broadcast_frame_filter (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxValid(rxValid), .rxByte(rxByte),
        .rxReady(rxReady), .verdictValid(verdictValid), .verdict(verdict),
        .verdictReady(verdictReady));
    frame_source u_frame_source (.core_clk(core_clk), .rxReady(rxReady), .rxValid(rxValid),
        .rxByte(rxByte), .hung(hung));
    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic wrap_up;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic stop;
        error_cnt++;
        $display("Error at %0t: wait ran out", $time);
        wrap_up();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request stands until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) stop();
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // Wait for the queued verdict, compare it, then pop it
    task automatic pop(input logic bc, input logic fw, input logic [3:0] c);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (verdictValid !== 1'b1 && n < 200);
        if (n >= 200) stop();
        chk({26'h0, verdict.bcast, verdict.forward, verdict.cls}, {26'h0, bc, fw, c});
        verdictReady <= 1'b1;
        @(posedge core_clk);
        verdictReady <= 1'b0;
    endtask
    task automatic frame(input int k, input logic bc, input logic fw);
        u_frame_source.send(bc, ets[k], pts[k], 40);
        if (hung) stop();
        // Expected class bit comes from the class table; non-broadcast matches none
        pop(bc, fw, (bc && cls[k] < 4) ? 4'(1 << cls[k]) : 4'h0);
    endtask
    // Main sequence
    initial begin
        {rst, psel, penable, pwrite, verdictReady} = 5'h10;
        paddr       = 12'h000;
        pwdata      = 32'h0;
        error_cnt   = 0;
        comparisons = 0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0000000f);
        apb(1'b1, 12'h014, 32'h1);
        chk({31'h0, err}, 32'h1);
        frame(0, 1'b1, 1'b1);
        // Each class alone, then none; reserved bits are always set
        for (int s = 0; s < 5; s++) begin
            apb(1'b1, 12'h000, 32'hfffffff0 | (32'h1 << s));
            apb(1'b1, 12'h004, 32'h00000010);
            apb(1'b0, 12'h00c, 32'h0);
            chk(rd, 32'h00009001);
            apb(1'b0, 12'h008, 32'h0);
            chk(rd, 32'hfffffff0 | (32'h1 << s));
            for (int k = 0; k < 6; k++) frame(k, 1'b1, cls[k] == s);
            frame(0, 1'b0, 1'b1);
        end
        apb(1'b1, 12'h004, 32'h00000011);
        apb(1'b1, 12'h004, 32'h00000055);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h00009100);
        frame(1, 1'b1, 1'b1);
        // Stalled consumer: 16 verdicts fill the queue and stop the stream
        for (int i = 0; i < 16; i++) u_frame_source.send(1'b0, 16'h0, 16'h0, 1);
        if (hung) stop();
        chk({31'h0, rxReady}, 32'h0);
        for (int i = 0; i < 16; i++) pop(1'b0, 1'b1, 4'h0);
        @(posedge core_clk);
        chk({31'h0, rxReady}, 32'h1);
        wrap_up();
    end
endmodule // tb_broadcast_frame_filter
